// ==== kgs_pkg.sv ====
// Constants, field layout and carrier types of the keyclick and gain step
// control block.
// Assumes a single 10 MHz system clock and a 16-bit register port.
`default_nettype none
package kgs_pkg;
  // Register byte offsets.
  localparam logic [7:0] KGS_CTRL_OFS = 8'h04;
  localparam logic [7:0] KGS_STAT_OFS = 8'h10;
  localparam logic [7:0] KGS_MASK_OFS = 8'h14;
  // Field positions of the control register.
  localparam int KGS_TRIG_POS = 15;
  localparam int KGS_LVL_LSB = 12;
  localparam int KGS_MRATE_POS = 11;
  localparam int KGS_FREQ_LSB = 8;
  localparam int KGS_DUR_LSB = 4;
  localparam int KGS_LSET_POS = 3;
  localparam int KGS_RSET_POS = 2;
  localparam int KGS_PRATE_POS = 1;
  localparam int KGS_MSET_POS = 0;
  // Reset values of the writable fields.
  localparam logic [2:0] KGS_LVL_RST = 3'h4;
  localparam logic [2:0] KGS_FREQ_RST = 3'h4;
  localparam logic [3:0] KGS_DUR_RST = 4'h1;
  // Status and mask bit positions.
  localparam int KGS_EV_CLICK = 0;
  localparam int KGS_EV_LSET = 1;
  localparam int KGS_EV_RSET = 2;
  localparam int KGS_EV_MSET = 3;
  localparam int KGS_EV_W = 4;
  // Timing: system clock and lowest tone frequency in millihertz.
  localparam longint KGS_CLK_HZ = 64'd10_000_000;
  localparam longint KGS_TONE_BASE_MHZ = 64'd62_500;
  // Clock cycles in half a period of the lowest tone (rounded down).
  localparam int KGS_HALF_BASE =
    int'((KGS_CLK_HZ * 64'd1000) / (64'd2 * KGS_TONE_BASE_MHZ));
  localparam int KGS_GAIN_W = 7;

  typedef struct packed {
    logic trig;
    logic [2:0] level;
    logic mic_rate;
    logic [2:0] freq;
    logic [3:0] dur;
    logic play_rate;
  } kgs_ctrl_t;

  typedef struct packed {
    logic [KGS_GAIN_W-1:0] left;
    logic [KGS_GAIN_W-1:0] right;
    logic [KGS_GAIN_W-1:0] mic;
  } kgs_gain_t;
endpackage
`default_nettype wire

// ==== kgs_ctrl.sv ====
// Keyclick tone generator and PGA soft-stepping control with its register.
// Assumes word clock and record word sync arrive as pins; gain targets and
// AGC flags come from logic on the same clock.
//
// Function
// [RULE1] Writing one starts a click; bit self-clears after set periods.
// [RULE2] Level scales amplitude: 000 lowest, 111 highest, reset 100.
// [RULE3] Tone frequency 62.5 Hz doubled per code up to 8 kHz, reset 1 kHz.
// [RULE4] Click length is two periods per code step plus two, reset four.
// [RULE5] Mic gain steps 0.5 dB per word tick, or per two ticks.
// [RULE6] Under AGC mic rate bit is read-only noise-below-threshold flag.
// [RULE7] Left settled flag reads one when applied left gain equals setting.
// [RULE8] Right settled flag reads one when applied right gain equals setting.
// [RULE9] Playback gains step 0.5 dB each word clock, or every second.
// [RULE10] Mic settled flag reads one when applied mic gain equals setting.
// [RULE11] Under AGC mic settled bit becomes read-only saturation flag.
// [RULE12] Playback codes are 0.5 dB steps; applied gain moves one code.
// [RULE13] Read-only bits ignore writes; retrigger mid-click does not restart.
`default_nettype none
module kgs_ctrl
  import kgs_pkg::*;
#(
  parameter int HALF_BASE = KGS_HALF_BASE
) (
  input wire logic clk_sys_in, // System clock, 10 MHz.
  input wire logic rst_in, // Asynchronous reset, active high.
  input wire logic clk_en_in, // Clock enable; state frozen when low.
  input wire logic [7:0] addr_in, // Register byte address.
  input wire logic [15:0] wdata_in, // Write data.
  input wire logic wr_in, // Write strobe.
  input wire logic rd_in, // Read strobe.
  output logic [15:0] rdata_out, // Read data, cycle after the strobe.
  input wire logic word_clk_in, // Audio word clock pin.
  input wire logic record_word_sync_in, // ADC word sync pin.
  input wire logic agc_on_in, // AGC active on the mic path.
  input wire logic agc_noise_low_in, // Signal below noise threshold.
  input wire logic agc_saturated_in, // AGC has saturated.
  input wire logic [6:0] left_playback_level_in, // Programmed left code.
  input wire logic [6:0] right_playback_level_in, // Programmed right code.
  input wire logic [6:0] mic_gain_level_in, // Programmed mic code.
  output kgs_gain_t gain_out, // Applied gain codes.
  output logic tone_out, // Keyclick square wave.
  output logic tone_active_out, // Keyclick playing.
  output logic [2:0] click_level_out, // Keyclick amplitude code.
  output logic irq_out // Level interrupt.
);

  localparam int HW = $clog2(HALF_BASE + 1);

  // Step toward a target by one code.
  function automatic logic [6:0] step_to(input logic [6:0] cur,
                                         input logic [6:0] tgt);
    if (cur < tgt) begin
      step_to = cur + 7'h01;
    end else if (cur > tgt) begin
      step_to = cur - 7'h01;
    end else begin
      step_to = cur;
    end
  endfunction

  // Pin synchronisers and edge detection.
  logic [2:0] wclk_reg, wclk_next;
  logic [2:0] rws_reg, rws_next;
  logic wclk_tick, rws_tick;

  always_comb begin
    wclk_next = {wclk_reg[1:0], word_clk_in};
    rws_next = {rws_reg[1:0], record_word_sync_in};
    wclk_tick = wclk_reg[1] & ~wclk_reg[2];
    rws_tick = rws_reg[1] & ~rws_reg[2];
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wclk_reg <= 3'h0;
      rws_reg <= 3'h0;
    end else if (clk_en_in) begin
      wclk_reg <= wclk_next;
      rws_reg <= rws_next;
    end
  end

  // Register file, keyclick generator and soft-stepping.
  kgs_ctrl_t ctrl_reg, ctrl_next;
  logic [KGS_EV_W-1:0] stat_reg, stat_next, mask_reg, mask_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [HW-1:0] half_cnt_reg, half_cnt_next;
  logic [6:0] halves_reg, halves_next;
  logic tone_reg, tone_next;
  logic irq_reg, irq_next;
  kgs_gain_t gain_reg, gain_next;
  logic play_div_reg, play_div_next;
  logic mic_div_reg, mic_div_next;
  logic lset, rset, mset, lset_q_reg, rset_q_reg, mset_q_reg;
  logic [KGS_EV_W-1:0] ev;
  logic wr_ctrl, click_done;
  logic [6:0] halves_total;
  logic [HW-1:0] half_len;
  logic play_step, mic_tick, mic_step;
  logic [15:0] ctrl_view;

  always_comb begin
    lset = gain_reg.left == left_playback_level_in; // RULE7
    rset = gain_reg.right == right_playback_level_in; // RULE8
    mset = gain_reg.mic == mic_gain_level_in; // RULE10
    // Four half periods per code step, starting at four.
    halves_total = {1'b0, ctrl_reg.dur, 2'b00} + 7'h04; // RULE4
    half_len = HW'(HALF_BASE >> ctrl_reg.freq); // RULE3
    wr_ctrl = wr_in && addr_in == KGS_CTRL_OFS;

    ctrl_view = 16'h0000;
    ctrl_view[KGS_TRIG_POS] = ctrl_reg.trig;
    ctrl_view[KGS_LVL_LSB +: 3] = ctrl_reg.level;
    ctrl_view[KGS_MRATE_POS] = agc_on_in ? agc_noise_low_in
                                         : ctrl_reg.mic_rate; // RULE6
    ctrl_view[KGS_FREQ_LSB +: 3] = ctrl_reg.freq;
    ctrl_view[KGS_DUR_LSB +: 4] = ctrl_reg.dur;
    ctrl_view[KGS_LSET_POS] = lset;
    ctrl_view[KGS_RSET_POS] = rset;
    ctrl_view[KGS_PRATE_POS] = ctrl_reg.play_rate;
    ctrl_view[KGS_MSET_POS] = agc_on_in ? agc_saturated_in : mset; // RULE11

    ctrl_next = ctrl_reg;
    half_cnt_next = half_cnt_reg;
    halves_next = halves_reg;
    tone_next = tone_reg;
    click_done = 1'b0;

    // Tone runs while the trigger bit is set.
    if (ctrl_reg.trig) begin
      if (half_cnt_reg >= half_len - HW'(1)) begin
        half_cnt_next = '0;
        tone_next = ~tone_reg;
        if (halves_reg + 7'h01 >= halves_total) begin
          ctrl_next.trig = 1'b0; // RULE1
          tone_next = 1'b0;
          halves_next = 7'h00;
          click_done = 1'b1;
        end else begin
          halves_next = halves_reg + 7'h01;
        end
      end else begin
        half_cnt_next = half_cnt_reg + HW'(1);
      end
    end

    if (wr_ctrl) begin
      ctrl_next.level = wdata_in[KGS_LVL_LSB +: 3]; // RULE2
      ctrl_next.freq = wdata_in[KGS_FREQ_LSB +: 3];
      ctrl_next.dur = wdata_in[KGS_DUR_LSB +: 4];
      ctrl_next.play_rate = wdata_in[KGS_PRATE_POS];
      if (!agc_on_in) begin
        ctrl_next.mic_rate = wdata_in[KGS_MRATE_POS]; // RULE13
      end
      if (!wdata_in[KGS_TRIG_POS]) begin
        // Writing zero stops a click in progress.
        ctrl_next.trig = 1'b0;
        tone_next = 1'b0;
        half_cnt_next = '0;
        halves_next = 7'h00;
      end else if (!ctrl_reg.trig) begin
        ctrl_next.trig = 1'b1; // RULE1
        half_cnt_next = '0;
        halves_next = 7'h00;
      end // RULE13
    end

    // Playback soft-stepping on word clock ticks.
    play_div_next = play_div_reg;
    play_step = 1'b0;
    if (wclk_tick) begin
      play_div_next = ~play_div_reg;
      play_step = !ctrl_reg.play_rate || play_div_reg; // RULE9
    end
    // Mic soft-stepping on word clock or record word sync ticks.
    mic_tick = wclk_tick | rws_tick;
    mic_div_next = mic_div_reg;
    mic_step = 1'b0;
    if (mic_tick) begin
      mic_div_next = ~mic_div_reg;
      mic_step = !ctrl_reg.mic_rate || mic_div_reg; // RULE5
    end
    gain_next = gain_reg;
    if (play_step) begin
      gain_next.left = step_to(gain_reg.left,
                               left_playback_level_in); // RULE12
      gain_next.right = step_to(gain_reg.right, right_playback_level_in);
    end
    if (mic_step && !agc_on_in) begin
      gain_next.mic = step_to(gain_reg.mic, mic_gain_level_in); // RULE5
    end

    // Sticky events; a new event wins over a write-one clear.
    ev = '0;
    ev[KGS_EV_CLICK] = click_done;
    ev[KGS_EV_LSET] = lset & ~lset_q_reg;
    ev[KGS_EV_RSET] = rset & ~rset_q_reg;
    ev[KGS_EV_MSET] = mset & ~mset_q_reg;
    stat_next = stat_reg;
    if (wr_in && addr_in == KGS_STAT_OFS) begin
      stat_next = stat_reg & ~wdata_in[KGS_EV_W-1:0];
    end
    stat_next = stat_next | ev;
    mask_next = mask_reg;
    if (wr_in && addr_in == KGS_MASK_OFS) begin
      mask_next = wdata_in[KGS_EV_W-1:0];
    end
    irq_next = |(stat_reg & mask_reg);

    rdata_next = 16'h0000;
    if (rd_in) begin
      unique case (addr_in)
        KGS_CTRL_OFS: rdata_next = ctrl_view;
        KGS_STAT_OFS: rdata_next = {12'h000, stat_reg};
        KGS_MASK_OFS: rdata_next = {12'h000, mask_reg};
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg <= '{trig: 1'b0, level: KGS_LVL_RST, mic_rate: 1'b0,
                    freq: KGS_FREQ_RST, dur: KGS_DUR_RST, play_rate: 1'b0};
      stat_reg <= '0;
      mask_reg <= '0;
      rdata_reg <= 16'h0000;
      half_cnt_reg <= '0;
      halves_reg <= 7'h00;
      tone_reg <= 1'b0;
      irq_reg <= 1'b0;
      gain_reg <= '0;
      play_div_reg <= 1'b0;
      mic_div_reg <= 1'b0;
      lset_q_reg <= 1'b1;
      rset_q_reg <= 1'b1;
      mset_q_reg <= 1'b1;
    end else if (clk_en_in) begin
      ctrl_reg <= ctrl_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      half_cnt_reg <= half_cnt_next;
      halves_reg <= halves_next;
      tone_reg <= tone_next;
      irq_reg <= irq_next;
      gain_reg <= gain_next;
      play_div_reg <= play_div_next;
      mic_div_reg <= mic_div_next;
      lset_q_reg <= lset;
      rset_q_reg <= rset;
      mset_q_reg <= mset;
    end
  end

  assign rdata_out = rdata_reg;
  assign gain_out = gain_reg;
  assign tone_out = tone_reg;
  assign tone_active_out = ctrl_reg.trig;
  assign click_level_out = ctrl_reg.level; // RULE2
  assign irq_out = irq_reg;

endmodule
`default_nettype wire

// ==== kgs_ctrl_assertions.sv ====
// Port-level checks of the keyclick and gain step control block.
// Assumes one clock domain; bound to every instance of kgs_ctrl.
`default_nettype none
module kgs_ctrl_chk
  import kgs_pkg::*;
(
  input wire logic clk_sys_in, // System clock.
  input wire logic rst_in, // Asynchronous reset.
  input wire logic clk_en_in, // Clock enable.
  input wire logic [7:0] addr_in, // Register address.
  input wire logic [15:0] wdata_in, // Write data.
  input wire logic wr_in, // Write strobe.
  input wire logic rd_in, // Read strobe.
  input wire logic [15:0] rdata_out, // Read data.
  input wire logic agc_on_in, // AGC active.
  input wire logic agc_noise_low_in, // Noise flag.
  input wire logic agc_saturated_in, // Saturation flag.
  input wire kgs_gain_t gain_out, // Applied gains.
  input wire logic tone_out, // Tone wave.
  input wire logic tone_active_out, // Click playing.
  input wire logic [2:0] click_level_out, // Amplitude code.
  input wire logic irq_out // Interrupt.
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  logic wr_ctrl;
  logic rd_ctrl;
  assign wr_ctrl = clk_en_in && wr_in && addr_in == KGS_CTRL_OFS;
  assign rd_ctrl = clk_en_in && rd_in && addr_in == KGS_CTRL_OFS;
  property p_rd_idle;
    clk_en_in && !rd_in |=> rdata_out == 16'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_trig;
    wr_ctrl && wdata_in[15] && !tone_active_out |=> tone_active_out;
  endproperty
  a_trig: assert property (p_trig) else $error("click not started");
  property p_quiet;
    !tone_active_out |-> !tone_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("tone while idle");
  property p_level;
    wr_ctrl |=> click_level_out == $past(wdata_in[14:12]);
  endproperty
  a_level: assert property (p_level) else $error("level wrong");
  property p_noise;
    rd_ctrl && agc_on_in |=> rdata_out[11] == $past(agc_noise_low_in);
  endproperty
  a_noise: assert property (p_noise) else $error("noise flag wrong");
  property p_sat;
    rd_ctrl && agc_on_in |=> rdata_out[0] == $past(agc_saturated_in);
  endproperty
  a_sat: assert property (p_sat) else $error("sat flag wrong");
  property p_step;
    $changed(gain_out.left) |->
      gain_out.left - $past(gain_out.left) inside {7'h1, 7'h7f};
  endproperty
  a_step: assert property (p_step) else $error("left gain jumped");
  property p_mic_hold;
    agc_on_in && clk_en_in |=> $stable(gain_out.mic);
  endproperty
  a_mic_hold: assert property (p_mic_hold) else $error("mic moved");
  c_click: cover property ($rose(tone_active_out));
  c_irq: cover property ($rose(irq_out));
  c_agc: cover property (rd_ctrl && agc_on_in);
endmodule
bind kgs_ctrl kgs_ctrl_chk u_chk (.clk_sys_in, .rst_in, .clk_en_in,
  .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .agc_on_in,
  .agc_noise_low_in, .agc_saturated_in, .gain_out, .tone_out,
  .tone_active_out, .click_level_out, .irq_out);
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench of the keyclick and gain step control block.
// Assumes the package constants and a shortened tone half period of 128.
`default_nettype none
module tb_top
  import kgs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, wclk = 0;
  logic agc = 0, noise = 0, sat = 0, tone, act, irq;
  logic rws = 0, en = 1;
  logic [7:0] addr_in = 0;
  logic [15:0] wdata_in = 0, rdata;
  logic [6:0] lvl_l = 0, lvl_r = 0, lvl_m = 0;
  logic [2:0] lvl;
  kgs_gain_t gain;
  int miscompares = 0, num_checks = 0, cyc = 0;
  kgs_ctrl #(.HALF_BASE(128)) u_dut (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .clk_en_in(en), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
    .word_clk_in(wclk), .record_word_sync_in(rws), .agc_on_in(agc),
    .agc_noise_low_in(noise), .agc_saturated_in(sat),
    .left_playback_level_in(lvl_l), .right_playback_level_in(lvl_r),
    .mic_gain_level_in(lvl_m), .gain_out(gain), .tone_out(tone),
    .tone_active_out(act), .click_level_out(lvl), .irq_out(irq));
  initial begin
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1;
    chk("read data", rdata, exp);
  endtask
  // One rising edge on the record word sync pin or on the word clock pin.
  task automatic tick(input logic rec);
    @(posedge clk_sys_in);
    if (rec) rws <= 1'b1;
    else wclk <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    rws <= 1'b0;
    wclk <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    #1;
  endtask
  // Level 6, tone code 6 (two cycles a half period), 4 periods: 16 cycles.
  task automatic play(input int two);
    int n;
    int rises;
    logic prev;
    n = 0;
    rises = 0;
    wr(KGS_CTRL_OFS, 16'he610);
    if (two != 0) wr(KGS_CTRL_OFS, 16'he610);
    #1;
    prev = tone;
    while (act === 1'b1 && n < 200) begin
      @(posedge clk_sys_in);
      #1;
      if (tone === 1'b1 && prev === 1'b0) rises++;
      prev = tone;
      n++;
    end
    chk("click length", 16'(n), 16'(16 - 2 * two));
    chk("tone periods", 16'(rises), 16'(4 - two));
  endtask
  task automatic t_reset;
    chk("level", 16'(lvl), 16'h4);
    rd_chk(KGS_CTRL_OFS, 16'h441d);
    rd_chk(KGS_STAT_OFS, 16'h0);
    rd_chk(8'h08, 16'h0);
  endtask
  task automatic t_click;
    wr(KGS_MASK_OFS, 16'h0001);
    play(0);
    chk("level", 16'(lvl), 16'h6);
    wr(KGS_STAT_OFS, 16'h0001);
    @(posedge clk_sys_in);
    #1;
    chk("irq", 16'(irq), 16'h0);
    play(1);
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk("irq", 16'(irq), 16'h1);
    rd_chk(KGS_CTRL_OFS, 16'h661d);
    rd_chk(KGS_STAT_OFS, 16'h0001);
    wr(KGS_STAT_OFS, 16'h0001);
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk("irq", 16'(irq), 16'h0);
  endtask
  task automatic t_step;
    @(posedge clk_sys_in);
    lvl_l <= 7'h2;
    lvl_m <= 7'h1;
    repeat (2) @(posedge clk_sys_in);
    rd_chk(KGS_CTRL_OFS, 16'h6614);
    tick(1'b0);
    chk("left", 16'(gain.left), 16'h1);
    tick(1'b0);
    chk("left", 16'(gain.left), 16'h2);
    chk("mic", 16'(gain.mic), 16'h1);
    rd_chk(KGS_CTRL_OFS, 16'h661d);
    rd_chk(KGS_STAT_OFS, 16'h000a);
    wr(KGS_CTRL_OFS, 16'h6612);
    lvl_r <= 7'h2;
    lvl_m <= 7'h2;
    // Record word sync alone steps the mic gain but not playback.
    tick(1'b1);
    chk("mic", 16'(gain.mic), 16'h2);
    chk("left", 16'(gain.left), 16'h2);
    tick(1'b0);
    tick(1'b0);
    chk("right", 16'(gain.right), 16'h1);
  endtask
  task automatic t_agc;
    @(posedge clk_sys_in);
    agc <= 1'b1;
    noise <= 1'b1;
    sat <= 1'b1;
    wr(KGS_CTRL_OFS, 16'h6e1f);
    rd_chk(KGS_CTRL_OFS, 16'h6e1b);
    @(posedge clk_sys_in);
    noise <= 1'b0;
    sat <= 1'b0;
    rd_chk(KGS_CTRL_OFS, 16'h661a);
    @(posedge clk_sys_in);
    agc <= 1'b0;
    rd_chk(KGS_CTRL_OFS, 16'h661b);
  endtask
  // A write while the clock enable is low must leave every field alone.
  task automatic t_hold;
    @(posedge clk_sys_in);
    en <= 1'b0;
    wr(KGS_CTRL_OFS, 16'h8000);
    en <= 1'b1;
    #1;
    chk("frozen trigger", 16'(act), 16'h0);
    rd_chk(KGS_CTRL_OFS, 16'h661b);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    #1;
    t_reset();
    t_click();
    t_step();
    t_agc();
    t_hold();
    test_done();
  end
endmodule
`default_nettype wire
